/* File: hsp_fifo.sv */
// Shift-register buffer whose head and flags are all flip-flops
`timescale 1ns/1ps
module hsp_fifo #(
    parameter int unsigned W     = 10,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic ce,
    hsp_strm_if.fifo  s
);
    localparam int unsigned CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem_r [DEPTH];
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          push;
    logic          pop;
    logic          valid_r;
    logic          ready_r;

    if (DEPTH < 2) begin : g_chk
        $error("hsp_fifo needs DEPTH of at least 2");
    end

    assign push       = s.in_valid & ready_r;
    assign pop        = valid_r & s.out_ready;
    assign s.in_ready = ready_r;
    assign s.out_valid = valid_r;
    assign s.out_data = mem_r[0];

    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + CW'(1);
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r   <= '0;
            valid_r <= 1'b0;
            ready_r <= 1'b1;
        end else if (ce) begin
            cnt_r   <= cnt_nxt;
            valid_r <= (cnt_nxt != '0);
            ready_r <= (cnt_nxt != CW'(DEPTH));
        end
    end

    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                mem_r[i] <= '0;
            end else if (ce) begin
                if (pop) begin
                    if (push && cnt_r == CW'(i + 1)) begin
                        mem_r[i] <= s.in_data;
                    end else if (i < DEPTH - 1) begin
                        mem_r[i] <= mem_r[(i < DEPTH - 1) ? i + 1 : i];
                    end
                end else if (push && cnt_r == CW'(i)) begin
                    mem_r[i] <= s.in_data;
                end
            end
        end
    end
endmodule

/* File: hsp_host_model.sv */
// Outside master processor driving the parallel host bus
`timescale 1ns/1ps
module hsp_host_model (
    input  wire logic       mclk,
    input  wire logic       comb_mode,
    input  wire logic [7:0] dev_o,
    input  wire logic       dev_oe,
    output logic      [7:0] pins,
    output logic            wr_n,
    output logic            rd_n,
    output logic            cs0_n,
    output logic            cs1_n,
    output logic            sel
);
    logic [7:0] drv = 8'h00;
    logic       drv_en = 1'b0;
    logic [7:0] idle_r = 8'h00;
    initial begin
        {wr_n, rd_n, cs0_n, cs1_n, sel} = 5'b11110;
    end
    // Undriven bus shows a pattern stepping by 8'h5B each clock, not held at the last byte
    always @(posedge mclk) idle_r <= idle_r + 8'h5B;
    assign pins = drv_en ? drv : (dev_oe ? dev_o : idle_r);
    task automatic xfer(input logic wr, ch, s, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge mclk);
        #1;
        cs0_n = ch;
        cs1_n = !ch;
        sel = s;
        drv = d;
        drv_en = wr;
        if (comb_mode) wr_n = !wr;
        @(posedge mclk);
        #1;
        if (comb_mode || !wr) rd_n = 1'b0;
        else wr_n = 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        q = pins;
        rd_n = 1'b1;
        if (!comb_mode) wr_n = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        {cs0_n, cs1_n, wr_n, drv_en} = 4'b1110;
        repeat (3) @(posedge mclk);
        #1;
    endtask
endmodule

/* File: hsp_pkg.sv */
// Constants shared by the host slave port, its checker and its bench
package hsp_pkg;
    localparam int unsigned SFR_AW     = 4;
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned RX_W       = 10;
    localparam int unsigned SYNC_W     = 13;
    // Local register indices on the special function register port
    localparam logic [3:0] SFR_STATUS0 = 4'h0;
    localparam logic [3:0] SFR_STATUS1 = 4'h1;
    localparam logic [3:0] SFR_IN0     = 4'h2;
    localparam logic [3:0] SFR_IN1     = 4'h3;
    localparam logic [3:0] SFR_OUT0    = 4'h4;
    localparam logic [3:0] SFR_OUT1    = 4'h5;
    localparam logic [3:0] SFR_CTL0    = 4'h6;
    localparam logic [3:0] SFR_CTL1    = 4'h7;
    localparam logic [3:0] SFR_PORTCTL = 4'h8;
    localparam logic [3:0] SFR_DIR     = 4'h9;
    // Field positions
    localparam int unsigned ST_OBF     = 0;
    localparam int unsigned ST_IBF     = 1;
    localparam int unsigned ST_CMD     = 3;
    localparam logic [7:0]  ST_HW_MASK = 8'h0B;
    localparam int unsigned CTL0_SLAVE = 7;
    localparam int unsigned CTL0_RWSTB = 6;
    localparam int unsigned CTL0_DMARX = 0;
    localparam int unsigned CTL1_DBL   = 7;
    localparam int unsigned PTC_TTL    = 7;
    // Reset values and the all-inputs direction value
    localparam logic [7:0]  REG_RST    = 8'h00;
    localparam logic [7:0]  DIR_RST    = 8'h00;
    localparam logic [7:0]  DIR_INPUTS = 8'h00;
    typedef enum logic [1:0] {
        HSP_ACC_IDLE  = 2'b00,
        HSP_ACC_WRITE = 2'b01,
        HSP_ACC_READ  = 2'b10
    } hsp_acc_t;
endpackage

/* File: hsp_strm_if.sv */
// Valid/ready stream between the port logic and its buffer
`timescale 1ns/1ps
interface hsp_strm_if #(parameter int unsigned W = 8);
    logic [W-1:0] in_data;
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] out_data;
    logic         out_valid;
    logic         out_ready;
    modport fifo (
        input  in_data,
        input  in_valid,
        input  out_ready,
        output in_ready,
        output out_data,
        output out_valid
    );
    modport user (
        output in_data,
        output in_valid,
        output out_ready,
        input  in_ready,
        input  out_data,
        input  out_valid
    );
endinterface

/* File: hsp_top.sv */
// Slave-side parallel port that trades bytes with an outside master
`timescale 1ns/1ps
module hsp_top
    import hsp_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 2
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic [7:0]        host_data_pins_i,
    output logic      [7:0]        host_data_pins_o,
    output logic                   host_data_pins_oe,
    input  wire logic              write_strobe_n,
    input  wire logic              read_strobe_n,
    input  wire logic              chip_select_first_n,
    input  wire logic              shared_select_pin,
    input  wire logic              register_select_line,
    input  wire logic [SFR_AW-1:0] sfr_addr,
    input  wire logic              sfr_wr,
    input  wire logic              sfr_rd,
    input  wire logic [7:0]        sfr_wdata,
    output logic      [7:0]        sfr_rdata,
    output logic      [1:0]        in_full_irq,
    output logic      [1:0]        out_empty_irq,
    output logic                   dma_rx_valid,
    input  wire logic              dma_rx_ready,
    output logic      [RX_W-1:0]   dma_rx_data,
    input  wire logic              dma_tx_valid,
    input  wire logic              dma_tx_chan,
    input  wire logic [7:0]        dma_tx_data,
    output logic      [1:0]        dma_tx_ready,
    output logic                   input_threshold_select,
    output logic                   port_active
);
    logic [7:0]        ctl0_r;
    logic [7:0]        ctl1_r;
    logic [7:0]        portctl_r;
    logic [7:0]        dir_r;
    logic [7:0]        user_r [2];
    logic [7:0]        in_byte_r [2];
    logic [7:0]        out_byte_r [2];
    logic [1:0]        obf_r;
    logic [1:0]        ibf_r;
    logic [1:0]        cmd_r;
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    hsp_acc_t          acc_r;
    hsp_acc_t          acc_nxt;
    logic [7:0]        cap_data_r;
    logic              cap_sel_r;
    logic              cap_ch_r;
    logic [7:0]        status [2];
    logic              active;
    logic              dbl_mode;
    logic              s_wr_n;
    logic              s_rd_n;
    logic              s_cs0_n;
    logic              s_cs1_n;
    logic              s_sel;
    logic [7:0]        s_data;
    logic              chan_hit;
    logic              chan_now;
    logic              wr_act;
    logic              rd_act;
    logic              acc_wr;
    logic              acc_rd;
    logic              host_wr_done;
    logic              host_rd_done;
    logic              rx_push;
    logic              rx_ch;
    logic [1:0]        sfr_out_wr;
    logic [1:0]        sfr_in_rd;
    logic [1:0]        tx_take;

    hsp_strm_if #(.W(RX_W)) rx_if ();

    hsp_fifo #(
        .W     (RX_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .mclk (mclk),
        .rst  (rst),
        .ce   (ce),
        .s    (rx_if)
    );

    // Pin inputs cross two flops before any logic looks at them
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_r <= '1;
            sync2_r <= '1;
        end else if (ce) begin
            sync1_r <= {host_data_pins_i, register_select_line,
                        shared_select_pin, chip_select_first_n,
                        read_strobe_n, write_strobe_n};
            sync2_r <= sync1_r;
        end
    end

    assign s_wr_n  = sync2_r[0];
    assign s_rd_n  = sync2_r[1];
    assign s_cs0_n = sync2_r[2];
    assign s_cs1_n = sync2_r[3];
    assign s_sel   = sync2_r[4];
    assign s_data  = sync2_r[12:5];

    assign active   = ctl0_r[CTL0_SLAVE] && (dir_r == DIR_INPUTS);
    assign dbl_mode = ctl1_r[CTL1_DBL];
    // Second pair answers only in double mode, on the shared pin
    assign chan_hit = !s_cs0_n || (dbl_mode && !s_cs1_n);
    assign chan_now = s_cs0_n;

    // Combined mode: write pin carries direction, read pin enables
    always_comb begin
        if (ctl0_r[CTL0_RWSTB]) begin
            wr_act = !s_rd_n && !s_wr_n;
            rd_act = !s_rd_n && s_wr_n;
        end else begin
            wr_act = !s_wr_n;
            rd_act = !s_rd_n;
        end
    end

    assign acc_wr = active && chan_hit && wr_act;
    assign acc_rd = active && chan_hit && rd_act;

    always_comb begin
        acc_nxt = acc_r;
        unique case (acc_r)
            HSP_ACC_IDLE: begin
                if (acc_wr) begin
                    acc_nxt = HSP_ACC_WRITE;
                end else if (acc_rd) begin
                    acc_nxt = HSP_ACC_READ;
                end
            end
            HSP_ACC_WRITE: begin
                if (!acc_wr) begin
                    acc_nxt = HSP_ACC_IDLE;
                end
            end
            HSP_ACC_READ: begin
                if (!acc_rd) begin
                    acc_nxt = HSP_ACC_IDLE;
                end
            end
            default: acc_nxt = HSP_ACC_IDLE;
        endcase
    end

    assign host_wr_done = (acc_r == HSP_ACC_WRITE) && !acc_wr;
    assign host_rd_done = (acc_r == HSP_ACC_READ) && !acc_rd;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acc_r      <= HSP_ACC_IDLE;
            cap_data_r <= REG_RST;
            cap_sel_r  <= 1'b0;
            cap_ch_r   <= 1'b0;
        end else if (ce) begin
            acc_r <= acc_nxt;
            if (acc_wr || acc_rd) begin
                cap_data_r <= s_data;
                cap_sel_r  <= s_sel;
                cap_ch_r   <= chan_now;
            end
        end
    end

    // Status byte: hardware flags over software bits
    for (genvar c = 0; c < 2; c++) begin : g_stat
        always_comb begin
            status[c]         = user_r[c] & ~ST_HW_MASK;
            status[c][ST_OBF] = obf_r[c];
            status[c][ST_IBF] = ibf_r[c];
            status[c][ST_CMD] = cmd_r[c];
        end
    end

    // Data pins driven only for the length of a host read
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            host_data_pins_o  <= REG_RST;
            host_data_pins_oe <= 1'b0;
        end else if (ce) begin
            host_data_pins_oe <= acc_rd;
            if (s_sel) begin
                host_data_pins_o <= status[chan_now];
            end else begin
                host_data_pins_o <= out_byte_r[chan_now];
            end
        end
    end

    assign rx_ch   = !ibf_r[0];
    assign rx_push = ctl0_r[CTL0_DMARX] && (ibf_r != 2'b00) &&
                     rx_if.in_ready;
    assign rx_if.in_valid  = rx_push;
    assign rx_if.in_data   = {rx_ch, cmd_r[rx_ch], in_byte_r[rx_ch]};
    assign rx_if.out_ready = dma_rx_ready;
    assign dma_rx_valid    = rx_if.out_valid;
    assign dma_rx_data     = rx_if.out_data;

    for (genvar c = 0; c < 2; c++) begin : g_chan
        assign sfr_out_wr[c] = sfr_wr && (sfr_addr == (c ? SFR_OUT1
                                                          : SFR_OUT0));
        assign sfr_in_rd[c]  = sfr_rd && (sfr_addr == (c ? SFR_IN1
                                                          : SFR_IN0));
        assign tx_take[c]    = dma_tx_valid && dma_tx_ready[c] &&
                               (dma_tx_chan == c[0]);

        // Host writes land in the input buffer with their select level
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                in_byte_r[c] <= REG_RST;
                cmd_r[c]     <= 1'b0;
                in_full_irq[c] <= 1'b0;
            end else if (ce) begin
                in_full_irq[c] <= host_wr_done && (cap_ch_r == c[0]);
                if (host_wr_done && cap_ch_r == c[0]) begin
                    in_byte_r[c] <= cap_data_r;
                    cmd_r[c]     <= cap_sel_r;
                end
            end
        end

        // Set wins over a clear in the same cycle
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                ibf_r[c] <= 1'b0;
            end else if (ce) begin
                if (host_wr_done && cap_ch_r == c[0]) begin
                    ibf_r[c] <= 1'b1;
                end else if (sfr_in_rd[c] ||
                             (rx_push && rx_ch == c[0])) begin
                    ibf_r[c] <= 1'b0;
                end
            end
        end

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                out_byte_r[c]    <= REG_RST;
                obf_r[c]         <= 1'b0;
                out_empty_irq[c] <= 1'b0;
                dma_tx_ready[c]  <= 1'b0;
            end else if (ce) begin
                out_empty_irq[c] <= host_rd_done && !cap_sel_r &&
                                    (cap_ch_r == c[0]);
                dma_tx_ready[c]  <= !obf_r[c] && !tx_take[c] &&
                                    !sfr_out_wr[c];
                if (sfr_out_wr[c]) begin
                    out_byte_r[c] <= sfr_wdata;
                    obf_r[c]      <= 1'b1;
                end else if (tx_take[c]) begin
                    out_byte_r[c] <= dma_tx_data;
                    obf_r[c]      <= 1'b1;
                end else if (host_rd_done && !cap_sel_r &&
                             cap_ch_r == c[0]) begin
                    obf_r[c] <= 1'b0;
                end
            end
        end

        // Software owns only the general status bits
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                user_r[c] <= REG_RST;
            end else if (ce) begin
                if (sfr_wr && sfr_addr == (c ? SFR_STATUS1
                                             : SFR_STATUS0)) begin
                    user_r[c] <= sfr_wdata & ~ST_HW_MASK;
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctl0_r    <= REG_RST;
            ctl1_r    <= REG_RST;
            portctl_r <= REG_RST;
            dir_r     <= DIR_RST;
        end else if (ce && sfr_wr) begin
            unique case (sfr_addr)
                SFR_CTL0:    ctl0_r    <= sfr_wdata;
                SFR_CTL1:    ctl1_r    <= sfr_wdata;
                SFR_PORTCTL: portctl_r <= sfr_wdata;
                SFR_DIR:     dir_r     <= sfr_wdata;
                default: ;
            endcase
        end
    end

    // Registered local read data; unmapped and write-only read zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= REG_RST;
        end else if (ce && sfr_rd) begin
            unique case (sfr_addr)
                SFR_STATUS0: sfr_rdata <= status[0];
                SFR_STATUS1: sfr_rdata <= status[1];
                SFR_IN0:     sfr_rdata <= in_byte_r[0];
                SFR_IN1:     sfr_rdata <= in_byte_r[1];
                SFR_CTL0:    sfr_rdata <= ctl0_r;
                SFR_CTL1:    sfr_rdata <= ctl1_r;
                SFR_PORTCTL: sfr_rdata <= portctl_r;
                SFR_DIR:     sfr_rdata <= dir_r;
                default:     sfr_rdata <= REG_RST;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            input_threshold_select <= 1'b0;
            port_active            <= 1'b0;
        end else if (ce) begin
            input_threshold_select <= portctl_r[PTC_TTL];
            port_active            <= active;
        end
    end
endmodule

/* File: hsp_top_sva.sv */
// Concurrent checks on the host slave port top-level ports
`timescale 1ns/1ps
module hsp_top_sva
    import hsp_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              write_strobe_n,
    input wire logic              read_strobe_n,
    input wire logic              host_data_pins_oe,
    input wire logic              port_active,
    input wire logic [1:0]        in_full_irq,
    input wire logic [1:0]        out_empty_irq,
    input wire logic [SFR_AW-1:0] sfr_addr,
    input wire logic              sfr_wr,
    input wire logic [7:0]        sfr_wdata,
    input wire logic              dma_tx_valid,
    input wire logic              dma_tx_chan,
    input wire logic [1:0]        dma_tx_ready,
    input wire logic              dma_rx_valid,
    input wire logic              dma_rx_ready,
    input wire logic [RX_W-1:0]   dma_rx_data,
    input wire logic              input_threshold_select
);
    logic [3:0] idle_cnt_r;
    logic       cfg_wr;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    assign cfg_wr = sfr_wr && (sfr_addr == SFR_CTL0 || sfr_addr == SFR_DIR);
    // Cycles since either strobe pin was last low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            idle_cnt_r <= 4'hF;
        end else if (!read_strobe_n || !write_strobe_n) begin
            idle_cnt_r <= 4'h0;
        end else if (idle_cnt_r != 4'hF) begin
            idle_cnt_r <= idle_cnt_r + 4'h1;
        end
    end
    AST_IN_IRQ_CAUSE: assert property (in_full_irq != 2'b00 |->
        port_active && idle_cnt_r <= 4'h8) else $error("stray input irq");
    AST_OUT_IRQ_CAUSE: assert property (out_empty_irq != 2'b00 |->
        idle_cnt_r <= 4'h8) else $error("stray output irq");
    AST_IRQ_PULSE: assert property (in_full_irq[0] |=> !in_full_irq[0])
        else $error("input irq longer than one cycle");
    AST_OE_ON_READ: assert property ($rose(host_data_pins_oe) |->
        !$past(read_strobe_n, 2)) else $error("pins driven without read");
    AST_OE_OFF_IDLE: assert property (!port_active [*4] |->
        !host_data_pins_oe) else $error("pins driven while port off");
    AST_TX_TAKE: assert property (dma_tx_valid && dma_tx_chan &&
        dma_tx_ready[1] |-> ##[1:2] !dma_tx_ready[1])
        else $error("dma load did not fill buffer");
    AST_OUT_WR: assert property (sfr_wr && sfr_addr == SFR_OUT0 |->
        ##[1:2] !dma_tx_ready[0]) else $error("output write kept empty");
    AST_RX_HOLD: assert property (dma_rx_valid && !dma_rx_ready |=>
        dma_rx_valid && $stable(dma_rx_data)) else $error("rx word lost");
    AST_TTL: assert property (sfr_wr && sfr_addr == SFR_PORTCTL |=>
        ##1 input_threshold_select == $past(sfr_wdata[PTC_TTL], 2))
        else $error("threshold select wrong");
    AST_ACT_CFG: assert property ($rose(port_active) |->
        $past(cfg_wr) || $past(cfg_wr, 2)) else $error("port woke alone");
    COV_IN1: cover property (in_full_irq[1]);
    COV_OUT0: cover property (out_empty_irq[0]);
    COV_STALL: cover property (dma_rx_valid && !dma_rx_ready);
    COV_OE: cover property ($rose(host_data_pins_oe));
endmodule
bind hsp_top hsp_top_sva hsp_top_sva_inst (
    .mclk(mclk), .rst(rst), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .host_data_pins_oe(host_data_pins_oe),
    .port_active(port_active), .in_full_irq(in_full_irq),
    .out_empty_irq(out_empty_irq), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .dma_tx_valid(dma_tx_valid),
    .dma_tx_chan(dma_tx_chan), .dma_tx_ready(dma_tx_ready),
    .dma_rx_valid(dma_rx_valid), .dma_rx_ready(dma_rx_ready),
    .dma_rx_data(dma_rx_data),
    .input_threshold_select(input_threshold_select)
);

/* File: hsp_top_test.sv */
// Self-checking bench for the host slave port
`timescale 1ns/1ps
module hsp_top_test
    import hsp_pkg::*;
;
    logic       mclk, rst, sfr_wr, sfr_rd, dma_rx_ready, dma_tx_valid;
    logic       dma_tx_chan, comb, dev_oe, wr_n, rd_n, cs0_n, cs1_n, sel;
    logic [3:0] sfr_addr;
    logic [7:0] sfr_wdata, dma_tx_data, sfr_rdata, dev_o, pins, d;
    logic [1:0] in_full_irq, out_empty_irq, dma_tx_ready;
    logic       dma_rx_valid, input_threshold_select, port_active;
    logic [9:0] dma_rx_data;
    logic [7:0] din[2], dout[2], sw[2];
    logic       cmd[2], ibf[2], obf[2];
    logic [9:0] rxq[$];
    int         ein[2], eout[2], nin[2] = '{0, 0}, nout[2] = '{0, 0};
    int         miscompares = 0, tests_run = 0;
    bit         act, dbl, rx;
    hsp_top hsp_top_inst (
        .mclk(mclk), .rst(rst), .ce(1'b1), .host_data_pins_i(pins),
        .host_data_pins_o(dev_o), .host_data_pins_oe(dev_oe),
        .write_strobe_n(wr_n), .read_strobe_n(rd_n),
        .chip_select_first_n(cs0_n), .shared_select_pin(cs1_n),
        .register_select_line(sel), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .in_full_irq(in_full_irq), .out_empty_irq(out_empty_irq),
        .dma_rx_valid(dma_rx_valid), .dma_rx_ready(dma_rx_ready),
        .dma_rx_data(dma_rx_data), .dma_tx_valid(dma_tx_valid),
        .dma_tx_chan(dma_tx_chan), .dma_tx_data(dma_tx_data),
        .dma_tx_ready(dma_tx_ready),
        .input_threshold_select(input_threshold_select),
        .port_active(port_active)
    );
    hsp_host_model hsp_host_model_inst (
        .mclk(mclk), .comb_mode(comb), .dev_o(dev_o), .dev_oe(dev_oe),
        .pins(pins), .wr_n(wr_n), .rd_n(rd_n), .cs0_n(cs0_n),
        .cs1_n(cs1_n), .sel(sel)
    );
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(negedge mclk) begin
        for (int c = 0; c < 2; c++) begin
            if (in_full_irq[c] === 1'b1) nin[c]++;
            if (out_empty_irq[c] === 1'b1) nout[c]++;
        end
    end
    task automatic chk(input logic [9:0] s, input logic [9:0] e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, s, e);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic [7:0] st(input int c);
        return {sw[c][7:4], cmd[c], sw[c][2], ibf[c], obf[c]};
    endfunction
    task automatic pause(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic lw(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        #1;
        {sfr_addr, sfr_wdata, sfr_wr} = {a, v, 1'b1};
        pause(1);
        sfr_wr = 1'b0;
    endtask
    task automatic lr(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        #1;
        {sfr_addr, sfr_rd} = {a, 1'b1};
        pause(1);
        sfr_rd = 1'b0;
        chk(10'(sfr_rdata), 10'(e));
    endtask
    task automatic rd_in(input int c);
        lr(4'(SFR_IN0 + c), din[c]);
        ibf[c] = 1'b0;
    endtask
    task automatic hw(input logic ch, s, input logic [7:0] v);
        logic [7:0] q;
        hsp_host_model_inst.xfer(1'b1, ch, s, v, q);
        if (act && (!ch || dbl)) begin
            ein[ch]++;
            din[ch] = v;
            cmd[ch] = s;
            if (rx) rxq.push_back({ch, s, v});
            else ibf[ch] = 1'b1;
        end
        chk(10'(nin[ch]), 10'(ein[ch]));
    endtask
    task automatic hr(input logic ch, s);
        logic [7:0] q, e;
        e = s ? st(ch) : dout[ch];
        hsp_host_model_inst.xfer(1'b0, ch, s, 8'h00, q);
        if (!s) begin
            obf[ch] = 1'b0;
            eout[ch]++;
        end
        chk(10'(q), 10'(e));
        chk(10'(nout[ch]), 10'(eout[ch]));
    endtask
    initial begin
        {rst, sfr_wr, sfr_rd, dma_rx_ready, dma_tx_valid} = 5'b10000;
        {dma_tx_chan, comb, sfr_addr, sfr_wdata, dma_tx_data} = '0;
        for (int c = 0; c < 2; c++) begin
            {din[c], dout[c], sw[c], cmd[c], ibf[c], obf[c]} = '0;
            {ein[c], eout[c]} = '0;
        end
        d = 8'($urandom(32'h88AE8712));
        pause(6);
        rst = 1'b0;
        pause(1);
        chk(10'(dma_tx_ready), 10'h003);
        lr(SFR_STATUS1, 8'h00);
        hw(1'b0, 1'b0, 8'($urandom));
        lr(SFR_STATUS0, 8'h00);
        lw(SFR_DIR, 8'hFF);
        lw(SFR_CTL0, 8'h80);
        pause(2);
        chk(10'(port_active), 10'h000);
        lw(SFR_DIR, DIR_INPUTS);
        act = 1'b1;
        pause(2);
        chk(10'(port_active), 10'h001);
        for (int v = 1; v >= 0; v--) begin
            lw(SFR_PORTCTL, 8'(v << PTC_TTL));
            pause(2);
            chk(10'(input_threshold_select), 10'(v));
        end
        for (int m = 0; m < 2; m++) begin
            lw(SFR_CTL0, m ? 8'hC0 : 8'h80);
            comb = m[0];
            for (int s = 0; s < 2; s++) begin
                hw(1'b0, s[0], 8'($urandom));
                lr(SFR_STATUS0, st(0));
                rd_in(0);
                lr(SFR_STATUS0, st(0));
            end
            d = 8'($urandom);
            lw(SFR_OUT0, d);
            {dout[0], obf[0]} = {d, 1'b1};
            hr(1'b0, 1'b1);
            hr(1'b0, 1'b0);
            lr(SFR_STATUS0, st(0));
        end
        lw(SFR_STATUS0, 8'hFF);
        sw[0] = 8'hFF;
        lr(SFR_STATUS0, st(0));
        hw(1'b0, 1'b1, 8'($urandom));
        hr(1'b0, 1'b1);
        rd_in(0);
        hw(1'b1, 1'b0, 8'($urandom));
        lr(SFR_STATUS1, st(1));
        lw(SFR_CTL1, 8'h80);
        dbl = 1'b1;
        hw(1'b1, 1'b1, 8'($urandom));
        lr(SFR_STATUS1, st(1));
        rd_in(1);
        d = 8'($urandom);
        {dma_tx_chan, dma_tx_data, dma_tx_valid} = {1'b1, d, 1'b1};
        pause(1);
        dma_tx_valid = 1'b0;
        {dout[1], obf[1]} = {d, 1'b1};
        pause(2);
        chk(10'(dma_tx_ready), 10'h001);
        hr(1'b1, 1'b0);
        chk(10'(dma_tx_ready), 10'h003);
        lr(SFR_OUT1, 8'h00);
        lr(4'hF, 8'h00);
        lw(SFR_CTL0, 8'h81);
        {comb, rx} = 2'b01;
        repeat (3) hw(1'($urandom), 1'($urandom), 8'($urandom));
        chk(10'(dma_rx_valid), 10'h001);
        dma_rx_ready = 1'b1;
        for (int i = 0; i < 100 && rxq.size() > 0; i++) begin
            @(negedge mclk);
            if (dma_rx_valid === 1'b1)
                chk(dma_rx_data, rxq.pop_front());
        end
        chk(10'(rxq.size()), 10'h000);
        lr(SFR_STATUS0, st(0));
        lr(SFR_STATUS1, st(1));
        complete_run();
    end
    initial begin
        #150000;
        miscompares++;
        complete_run();
    end
endmodule
